// *** bench/pws_host_model.sv ***
/* host side: latches whether the wake line is being pulled low.
   assumes one clock shared with the wake logic. */
`timescale 1ns/100ps
module pws_host_model (
    input wire logic i_clk,
    input wire logic i_wake_n,
    output logic o_seen
);
    // wake line sampled like a chipset input
    always_ff @(posedge i_clk) begin
        o_seen <= !i_wake_n;
    end
endmodule

// *** bench/pws_wake_checker.sv ***
/* port assertions for the wake logic.
   assumes binding to pws_wake_logic, one clock, synchronous reset. */
`timescale 1ns/100ps
module pws_wake_checker (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire pws_pkg::pws_byte_t i_reg_offset,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire pws_pkg::pws_byte_t i_reg_wdata,
    input wire pws_pkg::pws_byte_t o_reg_rdata,
    input wire pws_pkg::pws_byte_t i_source_enable_one,
    input wire pws_pkg::pws_byte_t i_source_enable_two,
    input wire pws_pkg::pws_byte_t i_source_enable_three,
    input wire logic o_wake_event_out_n
);
    import pws_pkg::*;
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    // ======================================================================
    // assertions
    property p_rsvd; i_reg_rd && (i_reg_offset == 8'h01 || i_reg_offset == 8'h03)
        |=> o_reg_rdata == 8'h00; endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved read not zero");
    property p_high; i_reg_rd && i_reg_offset > 8'h06 |=> o_reg_rdata == 8'h00; endproperty
    a_high: assert property (p_high) else $error("unmapped read not zero");
    property p_en; i_reg_rd && i_reg_offset == 8'h02 |=> o_reg_rdata[7:1] == 7'h00; endproperty
    a_en: assert property (p_en) else $error("enable upper bits not zero");
    property p_sum; i_reg_rd && i_reg_offset == 8'h00 |=> o_reg_rdata[7:1] == 7'h00; endproperty
    a_sum: assert property (p_sum) else $error("summary upper bits not zero");
    property p_hold; !i_reg_rd |=> $stable(o_reg_rdata); endproperty
    a_hold: assert property (p_hold) else $error("read data moved without read");
    property p_rel; i_reg_wr && i_reg_offset == 8'h00 && i_reg_wdata[0]
        |=> o_wake_event_out_n; endproperty
    a_rel: assert property (p_rel) else $error("wake not released on clear");
    property p_fall; $fell(o_wake_event_out_n)
        |-> |{i_source_enable_one, i_source_enable_two, i_source_enable_three}; endproperty
    a_fall: assert property (p_fall) else $error("wake low with no source enabled");
    property p_off; (i_reg_wr && i_reg_offset == 8'h02 && !i_reg_wdata[0])
        ##1 (!(i_reg_wr && i_reg_offset == 8'h02))[*2] |-> o_wake_event_out_n; endproperty
    a_off: assert property (p_off) else $error("wake low with master off");
    c_fall: cover property ($fell(o_wake_event_out_n));
    c_rd: cover property (i_reg_rd && i_reg_offset == 8'h04);
    c_clr: cover property (i_reg_wr && i_reg_offset == 8'h00 && i_reg_wdata[0]);
endmodule
bind pws_wake_logic pws_wake_checker pws_wake_checker_inst (.*);

// *** bench/pws_wake_logic_tb.sv ***
/* wake logic testbench: scenario tasks over the register strobes.
   assumes the checker is bound and the host model watches the wake pin. */
`timescale 1ns/100ps
module pws_wake_logic_tb;
    import pws_pkg::*;
    logic i_clk, i_rst_n, wr, rd, wake_n, seen;
    pws_byte_t off, wd, rdata, ev1, ev2, ev3, en1, en2, en3;
    int err_count, check_count;
    pws_wake_logic pws_wake_logic_inst (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_reg_offset(off),
        .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_wdata(wd), .o_reg_rdata(rdata),
        .i_consumer_infrared_wake(ev1[0]), .i_ring_indicator_port2(ev1[1]),
        .i_ring_indicator_port1(ev1[2]), .i_keyboard_wake(ev1[3]), .i_mouse_wake(ev1[4]),
        .i_specific_key_wake(ev1[5]), .i_fan_speed_input_one_wake(ev1[6]),
        .i_fan_speed_input_two_wake(ev1[7]), .i_general_pin_1x_wake(ev2),
        .i_general_pin_2x_low_wake(ev3[2:0]), .i_grouped_smi_status(ev3[3]),
        .i_general_pin_2x_high_wake(ev3[7:4]), .i_source_enable_one(en1),
        .i_source_enable_two(en2), .i_source_enable_three(en3), .o_wake_event_out_n(wake_n));
    pws_host_model pws_host_model_inst (.i_clk(i_clk), .i_wake_n(wake_n), .o_seen(seen));
    // ======================================================================
    // shared tasks
    task automatic chk(string what, pws_byte_t s, pws_byte_t e);
        check_count++;
        if (s !== e) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, s);
        end
    endtask
    task automatic wt(int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    task automatic wreg(pws_byte_t o, pws_byte_t d);
        @(posedge i_clk);
        off <= o;
        wd <= d;
        wr <= 1'b1;
        @(posedge i_clk);
        wr <= 1'b0;
    endtask
    task automatic rreg(pws_byte_t o, pws_byte_t e);
        @(posedge i_clk);
        off <= o;
        rd <= 1'b1;
        @(posedge i_clk);
        rd <= 1'b0;
        #1 chk("rdata", rdata, e);
    endtask
    task automatic pulse(pws_byte_t a, pws_byte_t b, pws_byte_t c);
        @(posedge i_clk);
        {ev1, ev2, ev3} <= {a, b, c};
        @(posedge i_clk);
        {ev1, ev2, ev3} <= 24'h000000;
        wt(2);
    endtask
    task automatic results();
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // ======================================================================
    // scenarios
    task automatic t_map();
        for (int i = 0; i < 8; i++) begin
            pulse(8'h01 << i, 8'h01 << i, 8'h01 << i);
            rreg(8'h04, 8'h01 << i);
            rreg(8'h05, 8'h01 << i);
            rreg(8'h06, 8'h01 << i);
            wreg(8'h04, 8'h01 << i);
            wreg(8'h05, 8'h01 << i);
            wreg(8'h06, 8'h01 << i);
        end
        rreg(8'h00, 8'h01);
        pulse(8'hFF, 8'h00, 8'h00);
        wreg(8'h04, 8'h00);
        rreg(8'h04, 8'hFF);
        wreg(8'h04, 8'h0F);
        rreg(8'h04, 8'hF0);
        wreg(8'h04, 8'hFF);
    endtask
    task automatic t_wake();
        pulse(8'h08, 8'h00, 8'h00);
        chk("wake_n", wake_n, 1'b1);
        rreg(8'h00, 8'h01);
        wreg(8'h02, 8'hFF);
        rreg(8'h02, 8'h01);
        chk("wake_n", wake_n, 1'b0);
        chk("seen", seen, 1'b1);
        wreg(8'h00, 8'h00);
        rreg(8'h00, 8'h01);
        wreg(8'h04, 8'h08);
        wreg(8'h00, 8'h01);
        wt(2);
        chk("wake_n", wake_n, 1'b1);
        rreg(8'h00, 8'h00);
        wreg(8'h02, 8'h00);
    endtask
    task automatic t_rsvd();
        wreg(8'h01, 8'hFF);
        wreg(8'h03, 8'hFF);
        rreg(8'h01, 8'h00);
        rreg(8'h03, 8'h00);
        rreg(8'h07, 8'h00);
    endtask
    task automatic t_reset();
        wreg(8'h02, 8'h01);
        pulse(8'h08, 8'hFF, 8'hFF);
        @(posedge i_clk);
        i_rst_n <= 1'b0;
        repeat (5) @(posedge i_clk);
        i_rst_n <= 1'b1;
        #1 chk("wake_n", wake_n, 1'b1);
        for (int i = 0; i < 7; i++) rreg(i[7:0], 8'h00);
    endtask
    initial begin
        i_clk = 1'b0;
        forever #50 i_clk = ~i_clk;
    end
    initial begin
        {i_rst_n, wr, rd, off, wd, ev1, ev2, ev3, en2, en3} = '0;
        en1 = 8'h08;
        repeat (5) @(posedge i_clk);
        i_rst_n <= 1'b1;
        t_map();
        t_wake();
        t_rsvd();
        t_reset();
        results();
    end
    initial begin
        wt(3000);
        err_count++;
        results();
    end
endmodule

// *** src/pws_defs.svh ***
/*
 * Register offsets, field positions and reset values of the wake register group.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef PWS_DEFS_SVH
`define PWS_DEFS_SVH

// ==========================================================================
// offsets from the wake register base
`define PWS_OFF_SUMMARY 8'h00
`define PWS_OFF_RSVD_A 8'h01
`define PWS_OFF_MASTER_EN 8'h02
`define PWS_OFF_RSVD_B 8'h03
`define PWS_OFF_STATUS_ONE 8'h04
`define PWS_OFF_STATUS_TWO 8'h05
`define PWS_OFF_STATUS_THREE 8'h06

// ==========================================================================
// fields and reset values
`define PWS_PENDING_BIT 0
`define PWS_MASTER_EN_BIT 0
`define PWS_GROUPED_SMI_BIT 3
`define PWS_RESET_VALUE 8'h00
`define PWS_READ_ZERO 8'h00

`endif

// *** src/pws_pkg.sv ***
/*
 * Types shared by the wake status logic.
 * Assumes the defs header is included alongside.
 */
package pws_pkg;
    typedef logic [7:0] pws_byte_t;
    typedef logic [2:0] pws_index_t;
endpackage

// *** src/pws_status_reg.sv ***
/*
 * One write-one-to-clear wake status register of eight sticky bits.
 * Assumes events are synchronous single-clock levels or pulses.
 */
`timescale 1ns/100ps
`include "pws_defs.svh"

module pws_status_reg (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire pws_pkg::pws_byte_t i_event,
    input wire logic i_clear_wr,
    input wire pws_pkg::pws_byte_t i_wdata,
    output pws_pkg::pws_byte_t o_status
);
    import pws_pkg::*;

    pws_byte_t status_reg;
    pws_byte_t status_next;

    // ======================================================================
    // sticky bits, set wins over clear
    always_comb begin
        status_next = status_reg;
        if (i_clear_wr) begin
            status_next = status_next & ~i_wdata; // R8
        end
        status_next = status_next | i_event; // R7
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            status_reg <= `PWS_RESET_VALUE; // R9
        end else begin
            status_reg <= status_next;
        end
    end

    assign o_status = status_reg;
endmodule

// *** src/pws_wake_logic.sv ***
/*
 * Runtime wake logic: summary pending flag, master enable, three status
 * registers and the active-low wake output.
 * Assumes i_rst_n is the standby power-on reset only; main-supply, soft and
 * hard resets are not wired here. Host accesses arrive already decoded
 * against the programmed base as a one-cycle read or write strobe with an
 * offset. Per-source enables come from outside as plain inputs.
 */
// Overview of operation
// R1: registers sit at byte offsets from the software-programmed wake register base.
// R2: the pending flag sets whenever the wake output would normally assert, regardless of master enable.
// R3: writing one to the pending flag clears it and releases the output; zero does nothing.
// R4: master enable bit 0 gates the output, default 0, bits 7 to 1 reserved.
// R5: pending flag and master enable clear only on standby power-on reset.
// R6: offsets 0x01 and 0x03 read zero and ignore writes.
// R7: each status bit sets on its source's event regardless of any enable.
// R8: writing one clears only that status bit; zero leaves it.
// R9: status registers clear only on standby power-on reset.
// R10: status one holds infrared, ring 2, ring 1, keyboard, mouse, key, fan 1, fan 2 in bits 0-7.
// R11: status two holds general pins 10 to 17 in bits 0 to 7.
// R12: status three holds pins 20-22, grouped SMI status in bit 3, pins 24-27 above.
// R13: status four and five bits that set on main-supply reset are outside this block.
// R14: a source drives the output only when status, its enable and master enable are all one; the latched pending flag holds it low after status or enable clears.
// R15: the output stays low while an enabled bit is set with master enable on; writing one to the pending flag still releases it for two cycles.
`timescale 1ns/100ps
`include "pws_defs.svh"

module pws_wake_logic (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire pws_pkg::pws_byte_t i_reg_offset,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire pws_pkg::pws_byte_t i_reg_wdata,
    output pws_pkg::pws_byte_t o_reg_rdata,
    input wire logic i_consumer_infrared_wake,
    input wire logic i_ring_indicator_port2,
    input wire logic i_ring_indicator_port1,
    input wire logic i_keyboard_wake,
    input wire logic i_mouse_wake,
    input wire logic i_specific_key_wake,
    input wire logic i_fan_speed_input_one_wake,
    input wire logic i_fan_speed_input_two_wake,
    input wire pws_pkg::pws_byte_t i_general_pin_1x_wake,
    input wire logic [2:0] i_general_pin_2x_low_wake,
    input wire logic i_grouped_smi_status,
    input wire logic [3:0] i_general_pin_2x_high_wake,
    input wire pws_pkg::pws_byte_t i_source_enable_one,
    input wire pws_pkg::pws_byte_t i_source_enable_two,
    input wire pws_pkg::pws_byte_t i_source_enable_three,
    output logic o_wake_event_out_n
);
    import pws_pkg::*;

    logic wake_pending_flag_reg;
    logic wake_master_enable_bit_reg;
    pws_byte_t rdata_reg;
    pws_byte_t event_one;
    pws_byte_t event_two;
    pws_byte_t event_three;
    pws_byte_t status_one;
    pws_byte_t status_two;
    pws_byte_t status_three;
    logic wake_request;
    logic wr_summary;

    function automatic logic wr_at(input pws_byte_t off);
        wr_at = i_reg_wr && (i_reg_offset == off); // R1
    endfunction

    // ======================================================================
    // source bit mapping
    assign event_one = {i_fan_speed_input_two_wake, i_fan_speed_input_one_wake,
                        i_specific_key_wake, i_mouse_wake, i_keyboard_wake,
                        i_ring_indicator_port1, i_ring_indicator_port2,
                        i_consumer_infrared_wake}; // R10
    assign event_two = i_general_pin_1x_wake; // R11
    assign event_three = {i_general_pin_2x_high_wake, i_grouped_smi_status,
                          i_general_pin_2x_low_wake}; // R12

    pws_status_reg u_status_one (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_event(event_one),
        .i_clear_wr(wr_at(`PWS_OFF_STATUS_ONE)),
        .i_wdata(i_reg_wdata),
        .o_status(status_one)
    );

    pws_status_reg u_status_two (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_event(event_two),
        .i_clear_wr(wr_at(`PWS_OFF_STATUS_TWO)),
        .i_wdata(i_reg_wdata),
        .o_status(status_two)
    );

    pws_status_reg u_status_three (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_event(event_three),
        .i_clear_wr(wr_at(`PWS_OFF_STATUS_THREE)),
        .i_wdata(i_reg_wdata),
        .o_status(status_three)
    );

    // ======================================================================
    // wake request: any enabled status bit set
    assign wake_request = |(status_one & i_source_enable_one) |
                          |(status_two & i_source_enable_two) |
                          |(status_three & i_source_enable_three); // R14

    // ======================================================================
    // summary pending flag
    assign wr_summary = wr_at(`PWS_OFF_SUMMARY) && i_reg_wdata[`PWS_PENDING_BIT];

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            wake_pending_flag_reg <= 1'b0; // R5
        end else if (wake_request && !wr_summary) begin
            wake_pending_flag_reg <= 1'b1; // R2
        end else if (wr_summary) begin
            wake_pending_flag_reg <= 1'b0; // R3
        end
    end

    // ======================================================================
    // master enable
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            wake_master_enable_bit_reg <= 1'b0; // R5
        end else if (wr_at(`PWS_OFF_MASTER_EN)) begin
            wake_master_enable_bit_reg <= i_reg_wdata[`PWS_MASTER_EN_BIT]; // R4
        end
    end

    // ======================================================================
    // wake output: pending and enabled; clearing the flag releases it
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_wake_event_out_n <= 1'b1;
        end else begin
            o_wake_event_out_n <= !(wake_pending_flag_reg && wake_master_enable_bit_reg
                                    && !wr_summary); // R15
        end
    end

    // ======================================================================
    // read data, registered one cycle after the strobe
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            rdata_reg <= `PWS_READ_ZERO;
        end else if (i_reg_rd) begin
            case (i_reg_offset)
                `PWS_OFF_SUMMARY: rdata_reg <= {7'h00, wake_pending_flag_reg};
                `PWS_OFF_MASTER_EN: rdata_reg <= {7'h00, wake_master_enable_bit_reg}; // R4
                `PWS_OFF_STATUS_ONE: rdata_reg <= status_one;
                `PWS_OFF_STATUS_TWO: rdata_reg <= status_two;
                `PWS_OFF_STATUS_THREE: rdata_reg <= status_three;
                default: rdata_reg <= `PWS_READ_ZERO; // R6
            endcase
        end
    end

    assign o_reg_rdata = rdata_reg;
endmodule
